/* File: hw/switchgear_control_logic.sv */
/*
 switchgear position supervision, commanding and trip routing for several devices.
 contact and command pins are asynchronous and synchronised here; settings are static.
*/
// What this block does
// - closed contact true means closed
// - open contact true means open
// - earth contact replaces normal contact when earthing
// - ready input gives ready flag for others
// - withdrawn input reported per switchgear
// - close travel supervision time setting
// - open travel supervision time setting
// - any close lockout rejects close command
// - any open lockout rejects open command
// - manual, external, lockout, close and open relays only when controlled
// - break-capable uncontrolled gets trips, no manual
// - neither property: only monitor position
// - trip handling only with break capability
// - trips go to switchgear 1 by default
// - external close and open requests accepted
// - relay ORs up to seven selected sources
// - relay sources address switchgear by reorderable number; trip target by index
// - closed, open, intermediate, faulty states
// - codes 0 indeterm 1 open 2 closed 3 disturbed
// - trip command held at least hold time
// - option latches trip until acknowledged
`timescale 1ns/1ns
module switchgear_control_logic
    import switchgear_pkg::*;
#(
    parameter int NSG = switchgear_pkg::SG_COUNT,
    parameter int NREL = 2
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [NSG-1:0] closedContact,
    input wire logic [NSG-1:0] openContact,
    input wire logic [NSG-1:0] earthContact,
    input wire logic [NSG-1:0] earthMode,
    input wire logic [NSG-1:0] readyContact,
    input wire logic [NSG-1:0] withdrawnContact,
    input wire logic [NSG-1:0] isControlled,
    input wire logic [NSG-1:0] hasBreakCapability,
    input wire logic [NSG*switchgear_pkg::TIME_W-1:0] closeMoveTime,
    input wire logic [NSG*switchgear_pkg::TIME_W-1:0] openMoveTime,
    input wire logic [NSG*switchgear_pkg::LOCK_COUNT-1:0] close_lockout_input,
    input wire logic [NSG*switchgear_pkg::LOCK_COUNT-1:0] open_lockout_input,
    input wire logic [NSG-1:0] manualCloseReq,
    input wire logic [NSG-1:0] manualOpenReq,
    input wire logic [NSG-1:0] external_close_request,
    input wire logic [NSG-1:0] external_open_request,
    input wire logic protTrip,
    input wire logic [7:0] tripTarget,
    input wire logic [switchgear_pkg::TIME_W-1:0] trip_hold_time,
    input wire logic tripLatched,
    input wire logic trip_acknowledge,
    input wire logic [NSG*8-1:0] sgNumberMap,
    input wire logic [NREL*switchgear_pkg::RELAY_SRC_COUNT*switchgear_pkg::RELAY_SEL_W-1:0] relaySel,
    input wire logic [NREL*switchgear_pkg::RELAY_SRC_COUNT*8-1:0] relaySgNum,
    output logic [NSG*2-1:0] positionCode,
    output logic [NSG-1:0] readyFlag,
    output logic [NSG-1:0] withdrawnFlag,
    output logic [NSG-1:0] earthedFlag,
    output logic [NSG-1:0] closeCmd,
    output logic [NSG-1:0] openCmd,
    output logic [NSG-1:0] tripCmd,
    output logic [NSG-1:0] cmdRejected,
    output logic [NREL-1:0] relayOut
);
    import switchgear_pkg::*;

    // millisecond tick divider
    logic [TICK_W-1:0] tickCnt_q;
    logic tick;
    assign tick = (tickCnt_q == TICK_W'(TICK_CYCLES - 1));
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            tickCnt_q <= '0;
        else
            tickCnt_q <= tick ? '0 : tickCnt_q + 1'b1;
    end

    // synchronised pin bundle: 5 contacts + 4 requests + 6 lockouts + 1 pad bit per device, plus trip and acknowledge
    localparam int PW = NSG * 16 + 2;
    logic [PW-1:0] pinRaw;
    logic [PW-1:0] s1_q, s2_q, s3_q, pin_q;
    assign pinRaw = {protTrip, trip_acknowledge, closedContact, openContact, earthContact,
        readyContact, withdrawnContact, manualCloseReq, manualOpenReq,
        external_close_request, external_open_request, close_lockout_input,
        open_lockout_input, {NSG{1'b0}}};
    // three stage sampling; change accepted once stages two and three agree
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            pin_q <= '0;
        end
        else
        begin
            s1_q <= pinRaw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
        end
    end

    // unpack filtered bundle
    logic tripIn, ackIn;
    logic [NSG-1:0] cIn, oIn, eIn, rIn, wIn, mcIn, moIn, xcIn, xoIn;
    logic [NSG*LOCK_COUNT-1:0] clIn, olIn;
    logic [NSG-1:0] unusedPad;
    assign {tripIn, ackIn, cIn, oIn, eIn, rIn, wIn, mcIn, moIn, xcIn, xoIn, clIn, olIn,
        unusedPad} = pin_q;

    // request edge detection
    logic [NSG-1:0] reqC_q, reqO_q, trip_q;
    logic [NSG-1:0] reqCEdge, reqOEdge;
    logic [NSG-1:0] tripHit;
    logic [NSG-1:0] closeOk, openOk;
    logic [NSG-1:0] closeReq, openReq;
    logic [NSG-1:0] inClosed, inOpen;

    genvar g;
    generate
        for (g = 0; g < NSG; g++)
        begin : gSg
            move_t mv_q, mv_d;
            logic [TIME_W-1:0] mvCnt_q, holdCnt_q;
            logic [1:0] pos_q;
            logic tripAct_q, holdDone_q;
            logic moveOver;
            // earth contact stands in for closed contact
            assign inClosed[g] = earthMode[g] ? eIn[g] : cIn[g];
            assign inOpen[g] = oIn[g];
            assign closeReq[g] = isControlled[g] & (mcIn[g] | xcIn[g]);
            assign openReq[g] = isControlled[g] & (moIn[g] | xoIn[g]);
            assign reqCEdge[g] = closeReq[g] & ~reqC_q[g];
            assign reqOEdge[g] = openReq[g] & ~reqO_q[g];
            assign closeOk[g] = reqCEdge[g] & ~(|clIn[g*LOCK_COUNT +: LOCK_COUNT]);
            assign openOk[g] = reqOEdge[g] & ~(|olIn[g*LOCK_COUNT +: LOCK_COUNT]);
            // trip only to break-capable target; default target zero index
            assign tripHit[g] = tripIn & hasBreakCapability[g] & (tripTarget == 8'(g));
            assign moveOver = (mv_q != MV_IDLE) && (mvCnt_q == '0);

            // close travel timer; open travel timer
            always_comb
            begin
                mv_d = mv_q;
                case (mv_q)
                    MV_IDLE:
                        if (closeOk[g])
                            mv_d = MV_CLOSING;
                        else if (openOk[g] || (tripHit[g] && !trip_q[g]))
                            mv_d = MV_OPENING;
                    MV_CLOSING:
                        if ((inClosed[g] && !inOpen[g]) || moveOver)
                            mv_d = MV_IDLE;
                    MV_OPENING:
                        if ((inOpen[g] && !inClosed[g]) || moveOver)
                            mv_d = MV_IDLE;
                    default:
                        mv_d = MV_IDLE;
                endcase
            end

            // move state and timer
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    mv_q <= MV_IDLE;
                    mvCnt_q <= '0;
                end
                else
                begin
                    mv_q <= mv_d;
                    if (mv_q == MV_IDLE && mv_d == MV_CLOSING)
                        mvCnt_q <= closeMoveTime[g*TIME_W +: TIME_W];
                    else if (mv_q == MV_IDLE && mv_d == MV_OPENING)
                        mvCnt_q <= openMoveTime[g*TIME_W +: TIME_W];
                    else if (tick && mvCnt_q != '0)
                        mvCnt_q <= mvCnt_q - 1'b1;
                end
            end

            // intermediate while moving, disturbed on both or timeout
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                    pos_q <= POS_INDETERM;
                else if (inClosed[g] && inOpen[g])
                    pos_q <= POS_DISTURB;
                else if (inClosed[g])
                    pos_q <= POS_CLOSED;
                else if (inOpen[g])
                    pos_q <= POS_OPEN;
                else if (moveOver || mv_q == MV_IDLE && pos_q == POS_DISTURB)
                    pos_q <= POS_DISTURB;
                else if (mv_q != MV_IDLE || pos_q != POS_DISTURB)
                    pos_q <= POS_INDETERM;
            end

            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    tripAct_q <= 1'b0;
                    holdCnt_q <= '0;
                    holdDone_q <= 1'b0;
                end
                else if (tripHit[g])
                begin
                    tripAct_q <= 1'b1;
                    holdCnt_q <= trip_hold_time;
                    holdDone_q <= 1'b0;
                end
                else if (tripAct_q)
                begin
                    // one extra tick: the first tick may come right after the trip
                    if (tick && holdCnt_q != '0)
                        holdCnt_q <= holdCnt_q - 1'b1;
                    else if (tick)
                        holdDone_q <= 1'b1;
                    if (holdDone_q && (!tripLatched || ackIn))
                        tripAct_q <= 1'b0;
                end
            end

            // command pulses only after checks; no manual without control
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    closeCmd[g] <= 1'b0;
                    openCmd[g] <= 1'b0;
                    tripCmd[g] <= 1'b0;
                    cmdRejected[g] <= 1'b0;
                    positionCode[g*2 +: 2] <= POS_INDETERM;
                end
                else
                begin
                    closeCmd[g] <= closeOk[g] & ~tripAct_q;
                    openCmd[g] <= openOk[g];
                    tripCmd[g] <= tripAct_q;
                    cmdRejected[g] <= (reqCEdge[g] & ~closeOk[g]) | (reqOEdge[g] & ~openOk[g])
                        | (reqCEdge[g] & tripAct_q);
                    positionCode[g*2 +: 2] <= pos_q;
                end
            end
        end
    endgenerate

    // edge registers and flags; ready flag; withdrawn flag
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            reqC_q <= '0;
            reqO_q <= '0;
            trip_q <= '0;
            readyFlag <= '0;
            withdrawnFlag <= '0;
            earthedFlag <= '0;
        end
        else
        begin
            reqC_q <= closeReq;
            reqO_q <= openReq;
            trip_q <= tripHit;
            readyFlag <= rIn;
            withdrawnFlag <= wIn;
            earthedFlag <= earthMode & eIn;
        end
    end

    // map protocol number to device index
    function automatic logic [NSG-1:0] numToMask(input logic [7:0] num);
        numToMask = '0;
        for (int i = 0; i < NSG; i++)
            if (sgNumberMap[i*8 +: 8] == num)
                numToMask[i] = 1'b1;
    endfunction

    // each relay ORs up to seven selected sources; close and open commands only from controlled
    logic [NREL-1:0] relayD;
    always_comb
    begin
        relayD = '0;
        for (int r = 0; r < NREL; r++)
            for (int k = 0; k < RELAY_SRC_COUNT; k++)
            begin
                logic [NSG-1:0] m;
                logic [RELAY_SEL_W-1:0] s;
                m = numToMask(relaySgNum[(r*RELAY_SRC_COUNT+k)*8 +: 8]);
                s = relaySel[(r*RELAY_SRC_COUNT+k)*RELAY_SEL_W +: RELAY_SEL_W];
                if (s == SRC_CLOSE && |(m & closeCmd & isControlled))
                    relayD[r] = 1'b1;
                if (s == SRC_OPEN && |(m & openCmd & isControlled))
                    relayD[r] = 1'b1;
                if (s == SRC_TRIP && |(m & tripCmd))
                    relayD[r] = 1'b1;
                if (s == SRC_READY && |(m & readyFlag))
                    relayD[r] = 1'b1;
            end
    end

    // relay output register
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            relayOut <= '0;
        else
            relayOut <= relayD;
    end
endmodule // switchgear_control_logic

/* File: hw/switchgear_pkg.sv */
/*
 package for the switchgear control block: position codes, field counts, timing.
 assumes a single 20 MHz system clock.
*/
package switchgear_pkg;
    localparam int SG_COUNT = 2;
    localparam int LOCK_COUNT = 3;
    localparam int RELAY_SRC_COUNT = 7;
    localparam int TRIP_DEFAULT_SG = 0;
    localparam int CLK_HZ = 20000000;
    // position codes as reported
    localparam logic [1:0] POS_INDETERM = 2'h0;
    localparam logic [1:0] POS_OPEN = 2'h1;
    localparam logic [1:0] POS_CLOSED = 2'h2;
    localparam logic [1:0] POS_DISTURB = 2'h3;
    // one tick per millisecond for the supervision and hold timers
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int TICK_W = 15;
    localparam int TIME_W = 16;
    // relay source codes
    localparam int RELAY_SEL_W = 3;
    localparam logic [2:0] SRC_NONE = 3'h0;
    localparam logic [2:0] SRC_CLOSE = 3'h1;
    localparam logic [2:0] SRC_OPEN = 3'h2;
    localparam logic [2:0] SRC_TRIP = 3'h3;
    localparam logic [2:0] SRC_READY = 3'h4;
    typedef enum logic [1:0] {MV_IDLE, MV_CLOSING, MV_OPENING} move_t;
endpackage

/* File: dv/breaker_model.sv */
/*
 behavioural mechanics of the switching devices behind the block.
 coils come from the block's command outputs; travel time is in clock cycles.
*/
`timescale 1ns/1ns
module breaker_model
#(
    parameter int NSG = 2,
    parameter int TRAVEL = 40
)
(
    input wire logic clk_sys,
    input wire logic [NSG-1:0] closeCoil,
    input wire logic [NSG-1:0] openCoil,
    input wire logic [NSG-1:0] stuck,
    output logic [NSG-1:0] closedContact,
    output logic [NSG-1:0] openContact
);
    logic [NSG-1:0] toClose;
    // all devices start open
    initial
    begin
        closedContact = '0;
        openContact = '1;
    end
    // leave the end position at once, land after the travel unless jammed
    for (genvar g = 0; g < NSG; g++)
    begin : g_dev
        always @(posedge clk_sys)
        begin
            if (closeCoil[g] || openCoil[g])
            begin
                toClose[g] = closeCoil[g];
                closedContact[g] <= 1'b0;
                openContact[g] <= 1'b0;
                if (!stuck[g])
                begin
                    repeat (TRAVEL) @(posedge clk_sys);
                    closedContact[g] <= toClose[g];
                    openContact[g] <= !toClose[g];
                end
                while (closeCoil[g] || openCoil[g]) @(posedge clk_sys);
            end
        end
    end
endmodule // breaker_model

/* File: dv/switchgear_control_logic_asserts.sv */
/*
 concurrent checks on the switchgear block: gating, pulses, position codes.
 bound to the top module; device 0 runs with earthMode low.
*/
`timescale 1ns/1ns
module switchgear_asserts
    import switchgear_pkg::*;
#(
    parameter int NSG = 2
)
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [NSG-1:0] closedContact,
    input wire logic [NSG-1:0] openContact,
    input wire logic [NSG-1:0] readyContact,
    input wire logic [NSG-1:0] isControlled,
    input wire logic [NSG-1:0] hasBreakCapability,
    input wire logic [NSG*switchgear_pkg::LOCK_COUNT-1:0] close_lockout_input,
    input wire logic [NSG*switchgear_pkg::LOCK_COUNT-1:0] open_lockout_input,
    input wire logic [NSG*2-1:0] positionCode,
    input wire logic [NSG-1:0] readyFlag,
    input wire logic [NSG-1:0] closeCmd,
    input wire logic [NSG-1:0] openCmd,
    input wire logic [NSG-1:0] tripCmd
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // contact pictures held long enough to pass the input filter
    sequence s_closedHeld;
        (closedContact[0] && !openContact[0])[*8] ##1 (closedContact[0] && !openContact[0])[*2];
    endsequence
    sequence s_openHeld;
        (openContact[0] && !closedContact[0])[*8] ##1 (openContact[0] && !closedContact[0])[*2];
    endsequence
    sequence s_bothHeld;
        (openContact[0] && closedContact[0])[*8] ##1 (openContact[0] && closedContact[0])[*2];
    endsequence
    property p_posClosed;
        s_closedHeld |-> positionCode[1:0] == POS_CLOSED;
    endproperty
    property p_posOpen;
        s_openHeld |-> positionCode[1:0] == POS_OPEN;
    endproperty
    property p_posDisturb;
        s_bothHeld |-> positionCode[1:0] == POS_DISTURB;
    endproperty
    property p_ctrlGate;
        ((closeCmd | openCmd) & ~isControlled) == '0;
    endproperty
    property p_tripGate;
        (tripCmd & ~hasBreakCapability) == '0;
    endproperty
    property p_pulse;
        (closeCmd[0] || openCmd[0]) |=> !closeCmd[0] && !openCmd[0];
    endproperty
    property p_closeLock;
        (close_lockout_input[2:0] != 3'h0)[*8] |-> !closeCmd[0];
    endproperty
    property p_openLock;
        (open_lockout_input[2:0] != 3'h0)[*8] |-> !openCmd[0];
    endproperty
    property p_ready;
        readyContact[0][*8] ##1 readyContact[0][*2] |-> readyFlag[0];
    endproperty
    a_posClosed: assert property (p_posClosed) else $error("closed contact not reported");
    a_posOpen: assert property (p_posOpen) else $error("open contact not reported");
    a_posDisturb: assert property (p_posDisturb) else $error("both contacts not disturbed");
    a_ctrlGate: assert property (p_ctrlGate) else $error("command on uncontrolled device");
    a_tripGate: assert property (p_tripGate) else $error("trip without break capability");
    a_pulse: assert property (p_pulse) else $error("command longer than one cycle");
    a_closeLock: assert property (p_closeLock) else $error("close passed lockout");
    a_openLock: assert property (p_openLock) else $error("open passed lockout");
    a_ready: assert property (p_ready) else $error("ready flag missing");
endmodule // switchgear_asserts
bind switchgear_control_logic switchgear_asserts #(.NSG(NSG)) u_switchgear_asserts (.clk_sys,
    .rst, .closedContact, .openContact, .readyContact, .isControlled, .hasBreakCapability,
    .close_lockout_input, .open_lockout_input, .positionCode, .readyFlag, .closeCmd,
    .openCmd, .tripCmd);

/* File: dv/testbench.sv */
/*
 self-checking bench for the switchgear control block, two devices, two relays.
 one 20 MHz clock; breaker mechanics come from breaker_model.
*/
`timescale 1ns/1ns
module testbench;
    import switchgear_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic protTrip = 1'b0;
    logic tripLatched = 1'b0;
    logic trip_acknowledge = 1'b0;
    logic [1:0] closedContact, openContact, earthContact, earthMode, readyContact;
    logic [1:0] withdrawnContact, isControlled, hasBreakCapability, stuck;
    logic [1:0] manualCloseReq, manualOpenReq, external_close_request, external_open_request;
    logic [5:0] close_lockout_input, open_lockout_input;
    logic [7:0] tripTarget;
    logic [15:0] trip_hold_time, sgNumberMap;
    logic [31:0] closeMoveTime, openMoveTime;
    logic [41:0] relaySel;
    logic [111:0] relaySgNum;
    logic [3:0] positionCode;
    logic [1:0] readyFlag, withdrawnFlag, earthedFlag, closeCmd, openCmd, tripCmd;
    logic [1:0] cmdRejected, relayOut, seenC, seenO, seenR, seenRel;
    int errCount = 0;
    int nChecks = 0;
    int cycles = 0;
    switchgear_control_logic #(.NSG(2), .NREL(2)) u_switchgear_control_logic (.clk_sys, .rst,
        .closedContact, .openContact, .earthContact, .earthMode, .readyContact,
        .withdrawnContact, .isControlled, .hasBreakCapability, .closeMoveTime, .openMoveTime,
        .close_lockout_input, .open_lockout_input, .manualCloseReq, .manualOpenReq,
        .external_close_request, .external_open_request, .protTrip, .tripTarget,
        .trip_hold_time, .tripLatched, .trip_acknowledge, .sgNumberMap, .relaySel, .relaySgNum,
        .positionCode, .readyFlag, .withdrawnFlag, .earthedFlag, .closeCmd, .openCmd, .tripCmd,
        .cmdRejected, .relayOut);
    breaker_model #(.NSG(2), .TRAVEL(40)) u_breaker_model (.clk_sys, .closeCoil(closeCmd),
        .openCoil(openCmd | tripCmd), .stuck, .closedContact, .openContact);
    // clock and hang guard
    initial
    begin
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 70000)
        begin
            errCount++;
            summarize();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
        #5;
    endtask
    task chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // watch command outputs for n cycles
    task run(input int n);
        {seenC, seenO, seenR, seenRel} = '0;
        repeat (n)
        begin
            tick(1);
            {seenC, seenO} = {seenC | closeCmd, seenO | openCmd};
            {seenR, seenRel} = {seenR | cmdRejected, seenRel | relayOut};
        end
    endtask
    task summarize();
        $display("checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // device 0 controlled, device 1 break-capable only, earthing on device 1
    initial
    begin
        {earthContact, readyContact, withdrawnContact, stuck, manualCloseReq} = '0;
        {manualOpenReq, external_close_request, external_open_request} = '0;
        {close_lockout_input, open_lockout_input, tripTarget, relaySel, relaySgNum} = '0;
        {isControlled, hasBreakCapability, earthMode, sgNumberMap} = {6'h1e, 16'h0201};
        {closeMoveTime, openMoveTime, trip_hold_time} = {16'h1, 16'h1, 16'h1, 16'h1, 16'h1};
        {relaySel[2:0], relaySel[41:39]} = {SRC_CLOSE, SRC_TRIP};
        {relaySgNum[7:0], relaySgNum[111:104]} = {8'h01, 8'h02};
        tick(3);
        rst = 1'b0;
        chk({closeCmd, openCmd, tripCmd, relayOut}, 16'h0);
        tick(20);
        chk(positionCode, {POS_OPEN, POS_OPEN});
        {readyContact, withdrawnContact, earthContact} = 6'h1a;
        tick(15);
        chk(readyFlag, 2'h1);
        chk(withdrawnFlag, 2'h2);
        chk(earthedFlag, 2'h2);
        close_lockout_input = 6'h04;
        manualCloseReq = 2'h1;
        run(20);
        chk({seenC, seenR}, 4'h1);
        {manualCloseReq, close_lockout_input, open_lockout_input, manualOpenReq} = 16'h0005;
        run(20);
        chk({seenO, seenR}, 4'h1);
        {open_lockout_input, manualOpenReq, external_close_request} = 10'h002;
        manualCloseReq = 2'h2;
        run(20);
        chk({seenC, seenO, seenR}, 6'h0);
        {manualCloseReq, external_close_request} = 4'h4;
        run(20);
        chk({seenC, seenRel}, 4'h5);
        tick(80);
        chk(positionCode[1:0], POS_CLOSED);
        {manualCloseReq, external_open_request} = 4'h1;
        run(20);
        chk(seenO, 2'h1);
        tick(80);
        chk(positionCode[1:0], POS_OPEN);
        {external_open_request, external_close_request} = 4'h1;
        run(20);
        chk(seenC, 2'h1);
        tick(80);
        {external_close_request, tripTarget, protTrip} = {2'h0, 8'h01, 1'b1};
        tick(20);
        protTrip = 1'b0;
        chk({tripCmd, relayOut[1]}, 3'h5);
        tick(19990);
        chk(tripCmd, 2'h2);
        tick(20000);
        chk(tripCmd, 2'h0);
        trip_hold_time = 16'h0;
        {stuck, tripTarget, tripLatched, protTrip} = {2'h1, 8'h00, 2'h3};
        tick(20);
        protTrip = 1'b0;
        tick(60);
        chk(tripCmd, 2'h1);
        chk(positionCode[1:0], POS_INDETERM);
        tick(25000);
        chk(tripCmd, 2'h1);
        chk(positionCode[1:0], POS_DISTURB);
        trip_acknowledge = 1'b1;
        tick(20);
        chk(tripCmd, 2'h0);
        summarize();
    end
endmodule // testbench
